/* File: logic/ddps_pkg.sv */
/*
  Constants shared by the dual data pointer select block: the special
  function register address, the field positions of the auxiliary pointer
  and boot control register, reset values and the pointer operation codes.
  Assumes an 8-bit special function register bus on the core clock.
*/
package ddps_pkg;

  // ----------------------------------------------------------------------
  // Register address and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] AUX_POINTER_BOOT_CONTROL_ADDR = 8'hA2;
  localparam int         POINTER_SELECT_BIT_POS        = 0;
  localparam int         STUCK_ZERO_BIT_POS            = 2;
  localparam int         USER_FLAG_BIT_POS             = 3;
  localparam int         BOOT_ROM_MAP_ENABLE_POS       = 5;
  localparam logic [7:0] AUX_IMPLEMENTED_MASK          = 8'h29;

  // Reset values; undefined bits settle to zero here.
  localparam logic       POINTER_SELECT_RESET          = 1'b0;
  localparam logic       USER_FLAG_RESET               = 1'b0;
  localparam logic       BOOT_ENABLE_RESET             = 1'b0;
  localparam logic [15:0] DATA_POINTER_RESET           = 16'h0000;

  // Boot ROM window in code space.
  localparam logic [15:0] BOOT_ROM_BASE                = 16'hF800;
  localparam logic [15:0] BOOT_ROM_TOP                 = 16'hFFFF;

  // ----------------------------------------------------------------------
  // Data pointer operations requested by the core
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DDPS_OP_NONE = 2'b00,
    DDPS_OP_LOAD = 2'b01,
    DDPS_OP_INC  = 2'b10
  } ddps_op_t;

endpackage

/* File: logic/ddps_pointer_bank.sv */
/*
  Bank of two 16-bit data pointers. Only the pointer chosen by the select
  input is loaded or incremented; the other keeps its value. The read data
  of the active pointer come out of a register.
  Assumes a synchronised active-low reset and operations from core logic.
*/
`timescale 1ns/1ps
module ddps_pointer_bank
  import ddps_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rstSync_n,
  input  wire logic            pointerSelect,
  input  wire ddps_pkg::ddps_op_t pointerOp,
  input  wire logic [15:0]     loadValue,
  output logic [15:0]          activePointer,
  output logic [15:0]          pointerZero,
  output logic [15:0]          pointerOne
);
  import ddps_pkg::*;

  logic [15:0] pointerReg [2];
  logic [15:0] nextPointer [2];
  logic [15:0] next_activePointer;

  // ----------------------------------------------------------------------
  // Next pointer values
  // ----------------------------------------------------------------------
  // Each slot is updated only when it is the selected one.
  for (genvar i = 0; i < 2; i++) begin : g_slot
    always_comb begin
      nextPointer[i] = pointerReg[i];
      if (pointerSelect == 1'(i)) begin
        case (pointerOp)
          DDPS_OP_LOAD: nextPointer[i] = loadValue;
          DDPS_OP_INC:  nextPointer[i] = pointerReg[i] + 16'h0001;
          default:      nextPointer[i] = pointerReg[i];
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        pointerReg[i] <= DATA_POINTER_RESET;
      end else begin
        pointerReg[i] <= nextPointer[i];
      end
    end
  end

  // Registered view of the currently selected pointer after this cycle's operation.
  always_comb begin
    next_activePointer = nextPointer[pointerSelect];
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      activePointer <= DATA_POINTER_RESET;
    end else begin
      activePointer <= next_activePointer;
    end
  end

  assign pointerZero = pointerReg[0];
  assign pointerOne  = pointerReg[1];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_idle_slot_holds;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (pointerOp != DDPS_OP_NONE && !pointerSelect) |=>
      pointerReg[1] == $past(pointerReg[1]);
  endproperty
  a_idle_slot_holds: assert property (p_idle_slot_holds)
    else $error("Unselected pointer one changed.");

  property p_inc_selected;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (pointerOp == DDPS_OP_INC && !pointerSelect) |=>
      pointerReg[0] == $past(pointerReg[0]) + 16'h0001;
  endproperty
  a_inc_selected: assert property (p_inc_selected)
    else $error("Selected pointer zero did not increment.");

endmodule

/* File: logic/ddps_top.sv */
/*
  Dual data pointer select block: the auxiliary pointer and boot control
  register on the special function register bus, two data pointers, and the
  boot ROM window decode for code fetches.
  Assumes a single-cycle byte-wide register bus and core pointer requests
  on the same clock.
*/
//
// Overview of operation
// - Two independent 16-bit data pointers each hold an external memory address.
// - Register bit 0 selects the active pointer: 0 is zero, 1 is one.
// - Bit 5 set maps boot ROM at F800h to FFFFh; cleared disables it.
// - Bit 3 is a plain user flag with no hardware effect.
// - Bit 2 always reads zero whatever is written.
// - Incrementing the register flips the select bit and leaves the flag.
// - Reset clears the select bit and bit 2 reads zero.
// - The register decodes at address A2h as a whole byte.
`timescale 1ns/1ps
module ddps_top
  import ddps_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         sfrAddr,
  input  wire logic               sfrWrite,
  input  wire logic               sfrRead,
  input  wire logic [7:0]         sfrWriteData,
  input  wire logic               sfrIncrement,
  output logic [7:0]              sfrReadData,
  output logic                    sfrHit,
  input  wire ddps_pkg::ddps_op_t pointerOp,
  input  wire logic [15:0]        pointerLoadValue,
  output logic [15:0]             dataPointer,
  input  wire logic [15:0]        codeFetchAddr,
  output logic                    bootRomSelect,
  output logic                    pointerSelectBit,
  output logic                    bootRomMapEnable,
  output logic                    userFlagBit
);
  import ddps_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rstMeta_n;
  logic rstSync_n;

  // Release is synchronised so that no flop leaves reset on a metastable edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic hitsAux(input logic [7:0] addr);
    hitsAux = (addr == AUX_POINTER_BOOT_CONTROL_ADDR);
  endfunction

  function automatic logic [7:0] auxImage(input logic sel, input logic flag,
                                          input logic boot);
    logic [7:0] img;
    img = 8'h00;
    img[POINTER_SELECT_BIT_POS]  = sel;
    img[USER_FLAG_BIT_POS]       = flag;
    img[BOOT_ROM_MAP_ENABLE_POS] = boot;
    auxImage = img;
  endfunction

  logic       next_pointerSelectBit;
  logic       next_userFlagBit;
  logic       next_bootRomMapEnable;
  logic [7:0] next_sfrReadData;
  logic       next_sfrHit;
  logic [7:0] incremented;

  // Register writes and read-modify-increment. The unimplemented bit 1 absorbs
  // the carry of bit 0, so an increment only toggles the select.
  always_comb begin
    incremented = auxImage(pointerSelectBit, userFlagBit, bootRomMapEnable)
                  + 8'h01;
    next_pointerSelectBit = pointerSelectBit;
    next_userFlagBit      = userFlagBit;
    next_bootRomMapEnable = bootRomMapEnable;
    if (hitsAux(sfrAddr) && sfrIncrement) begin
      next_pointerSelectBit = incremented[POINTER_SELECT_BIT_POS];
    end else if (hitsAux(sfrAddr) && sfrWrite) begin
      next_pointerSelectBit = sfrWriteData[POINTER_SELECT_BIT_POS];
      next_userFlagBit      = sfrWriteData[USER_FLAG_BIT_POS];
      next_bootRomMapEnable = sfrWriteData[BOOT_ROM_MAP_ENABLE_POS];
    end
    next_sfrHit      = hitsAux(sfrAddr) && (sfrRead || sfrWrite ||
                                            sfrIncrement);
    next_sfrReadData = 8'h00;
    if (hitsAux(sfrAddr) && sfrRead) begin
      next_sfrReadData = auxImage(pointerSelectBit, userFlagBit,
                                  bootRomMapEnable);
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pointerSelectBit <= POINTER_SELECT_RESET;
      userFlagBit      <= USER_FLAG_RESET;
      bootRomMapEnable <= BOOT_ENABLE_RESET;
      sfrReadData      <= 8'h00;
      sfrHit           <= 1'b0;
    end else begin
      pointerSelectBit <= next_pointerSelectBit;
      userFlagBit      <= next_userFlagBit;
      bootRomMapEnable <= next_bootRomMapEnable;
      sfrReadData      <= next_sfrReadData;
      sfrHit           <= next_sfrHit;
    end
  end

  // ----------------------------------------------------------------------
  // Boot ROM window
  // ----------------------------------------------------------------------
  logic next_bootRomSelect;

  // Registered so the output is glitch free; callers see it one cycle late.
  always_comb begin
    next_bootRomSelect = bootRomMapEnable &&
                         codeFetchAddr >= BOOT_ROM_BASE &&
                         codeFetchAddr <= BOOT_ROM_TOP;
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bootRomSelect <= 1'b0;
    end else begin
      bootRomSelect <= next_bootRomSelect;
    end
  end

  // ----------------------------------------------------------------------
  // Data pointers
  // ----------------------------------------------------------------------
  // The bank sees the current select; a select change takes effect for
  // pointer operations from the following cycle.
  ddps_pointer_bank u_bank (
    .sys_clk       (sys_clk),
    .rstSync_n     (rstSync_n),
    .pointerSelect (pointerSelectBit),
    .pointerOp     (pointerOp),
    .loadValue     (pointerLoadValue),
    .activePointer (dataPointer),
    .pointerZero   (),
    .pointerOne    ()
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_inc_toggles;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (sfrIncrement && hitsAux(sfrAddr)) |=>
      pointerSelectBit != $past(pointerSelectBit) &&
      userFlagBit == $past(userFlagBit);
  endproperty
  a_inc_toggles: assert property (p_inc_toggles)
    else $error("Increment did not toggle select cleanly.");

  property p_bit2_zero;
    @(posedge sys_clk) disable iff (!rstSync_n)
    sfrReadData[STUCK_ZERO_BIT_POS] == 1'b0;
  endproperty
  a_bit2_zero: assert property (p_bit2_zero)
    else $error("Bit 2 read as one.");

  property p_write_select;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (sfrWrite && !sfrIncrement && hitsAux(sfrAddr)) |=>
      pointerSelectBit == $past(sfrWriteData[POINTER_SELECT_BIT_POS]) &&
      userFlagBit == $past(sfrWriteData[USER_FLAG_BIT_POS]);
  endproperty
  a_write_select: assert property (p_write_select)
    else $error("Write did not set select and flag.");

  property p_boot_window;
    @(posedge sys_clk) disable iff (!rstSync_n)
    bootRomSelect |-> $past(bootRomMapEnable) &&
      $past(codeFetchAddr) >= BOOT_ROM_BASE;
  endproperty
  a_boot_window: assert property (p_boot_window)
    else $error("Boot ROM selected outside window.");

  property p_other_addr;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (!hitsAux(sfrAddr)) |=>
      pointerSelectBit == $past(pointerSelectBit) && !sfrHit;
  endproperty
  a_other_addr: assert property (p_other_addr)
    else $error("Foreign address touched the register.");

  property p_reset_select;
    @(posedge sys_clk) $rose(rstSync_n) |-> !pointerSelectBit;
  endproperty
  a_reset_select: assert property (p_reset_select)
    else $error("Select not cleared by reset.");

  property p_flag_read;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (sfrRead && hitsAux(sfrAddr) && !sfrWrite && !sfrIncrement) |=>
      sfrReadData[USER_FLAG_BIT_POS] == userFlagBit;
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("User flag read back wrong.");

  property p_pointer_follows;
    @(posedge sys_clk) disable iff (!rstSync_n)
    (pointerOp == DDPS_OP_LOAD && !sfrIncrement && !sfrWrite) |=>
      dataPointer == $past(pointerLoadValue);
  endproperty
  a_pointer_follows: assert property (p_pointer_follows)
    else $error("Active pointer did not take load.");

endmodule

/* File: tb/testbench.sv */
/*
  Self-checking bench for the dual data pointer select block. Register
  traffic comes from a table; boot window, pointer and reset cases follow.
  Assumes the block's top module and package from the logic folder.
*/
`timescale 1ns/1ps
module testbench;
  import ddps_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and table rows
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       inc;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       hit;
    logic [2:0] bits;
  } ddps_row_t;

  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [7:0]     sfrAddr = 8'h00;
  logic           sfrWrite = 1'b0;
  logic           sfrRead = 1'b0;
  logic [7:0]     sfrWriteData = 8'h00;
  logic           sfrIncrement = 1'b0;
  logic [7:0]     sfrReadData;
  logic           sfrHit;
  ddps_op_t       pointerOp = DDPS_OP_NONE;
  logic [15:0]    pointerLoadValue = 16'h0000;
  logic [15:0]    dataPointer;
  logic [15:0]    codeFetchAddr = 16'h0000;
  logic           bootRomSelect;
  logic           pointerSelectBit;
  logic           bootRomMapEnable;
  logic           userFlagBit;
  int             n_fail = 0;
  int             checks = 0;
  ddps_row_t      rows [16];
  logic [16:0]    fetches [5];

  // Clock at 200 MHz.
  always #2.5 sys_clk = ~sys_clk;

  ddps_top ddps_top_inst (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .sfrAddr          (sfrAddr),
    .sfrWrite         (sfrWrite),
    .sfrRead          (sfrRead),
    .sfrWriteData     (sfrWriteData),
    .sfrIncrement     (sfrIncrement),
    .sfrReadData      (sfrReadData),
    .sfrHit           (sfrHit),
    .pointerOp        (pointerOp),
    .pointerLoadValue (pointerLoadValue),
    .dataPointer      (dataPointer),
    .codeFetchAddr    (codeFetchAddr),
    .bootRomSelect    (bootRomSelect),
    .pointerSelectBit (pointerSelectBit),
    .bootRomMapEnable (bootRomMapEnable),
    .userFlagBit      (userFlagBit)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobes stay up for exactly one rising edge, then drop at the falling
  // edge, where the registered answer has settled for comparison. Each call
  // first lets a falling edge pass, so a strobe dropped by the previous call
  // is never raised again in the same time step.
  task automatic step(input logic [7:0] a, input logic w, input logic r,
                      input logic i, input logic [7:0] d);
    @(negedge sys_clk);
    sfrAddr = a;
    sfrWrite = w;
    sfrRead = r;
    sfrIncrement = i;
    sfrWriteData = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrIncrement = 1'b0;
  endtask

  task automatic pstep(input ddps_op_t op, input logic [15:0] v);
    @(negedge sys_clk);
    pointerOp = op;
    pointerLoadValue = v;
    @(posedge sys_clk);
    @(negedge sys_clk);
    pointerOp = DDPS_OP_NONE;
  endtask

  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the hundred or fewer cycles the run needs.
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    // Bits column is select, boot enable, user flag. Reserved bits are
    // never written with ones; bit 2 is, since it must drop them.
    rows = '{
      '{8'hA2, 1'b1, 1'b0, 1'b0, 8'h2D, 8'h00, 1'b1, 3'b111},
      '{8'hA2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h29, 1'b1, 3'b111},
      '{8'hA2, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 3'b011},
      '{8'hA2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h28, 1'b1, 3'b011},
      '{8'hA2, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 3'b111},
      '{8'hA2, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 3'b011},
      '{8'hA3, 1'b1, 1'b0, 1'b0, 8'h01, 8'h00, 1'b0, 3'b011},
      '{8'hA3, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 3'b011},
      '{8'hA2, 1'b1, 1'b0, 1'b0, 8'h04, 8'h00, 1'b1, 3'b000},
      '{8'hA2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 3'b000},
      '{8'hA2, 1'b1, 1'b0, 1'b0, 8'h08, 8'h00, 1'b1, 3'b001},
      '{8'hA2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h08, 1'b1, 3'b001},
      '{8'hA2, 1'b1, 1'b1, 1'b0, 8'h21, 8'h08, 1'b1, 3'b110},
      '{8'hA2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h21, 1'b1, 3'b110},
      '{8'hA2, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 3'b010},
      '{8'hA2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h20, 1'b1, 3'b010}
    };
    // Fetch address and whether the boot window claims it, enable set.
    fetches = '{{16'hF7FF, 1'b0}, {16'hF800, 1'b1}, {16'hFFFF, 1'b1},
                {16'h0000, 1'b0}, {16'hFC00, 1'b1}};
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check(pointerSelectBit, 1'b0);
    check(bootRomMapEnable, 1'b0);
    check(userFlagBit, 1'b0);
    step(8'hA2, 1'b0, 1'b1, 1'b0, 8'h00);
    check(sfrReadData, 16'h00);
    foreach (rows[k]) begin
      step(rows[k].addr, rows[k].wr, rows[k].rd, rows[k].inc, rows[k].wdata);
      check(sfrReadData, rows[k].rdata);
      check(sfrHit, rows[k].hit);
      check(pointerSelectBit, rows[k].bits[2]);
      check(bootRomMapEnable, rows[k].bits[1]);
      check(userFlagBit, rows[k].bits[0]);
    end
    // Boot window with the enable set, then one in-window fetch without it.
    foreach (fetches[k]) begin
      codeFetchAddr = fetches[k][16:1];
      @(posedge sys_clk);
      @(negedge sys_clk);
      check(bootRomSelect, fetches[k][0]);
    end
    step(8'hA2, 1'b1, 1'b0, 1'b0, 8'h00);
    codeFetchAddr = 16'hF800;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(bootRomSelect, 1'b0);
    // Pointer zero is active; fill it and wrap it past the top.
    pstep(DDPS_OP_LOAD, 16'hFFFF);
    check(dataPointer, 16'hFFFF);
    pstep(DDPS_OP_INC, 16'h0000);
    check(dataPointer, 16'h0000);
    pstep(DDPS_OP_INC, 16'h0000);
    check(dataPointer, 16'h0001);
    step(8'hA2, 1'b1, 1'b0, 1'b0, 8'h01);
    pstep(DDPS_OP_LOAD, 16'hABCD);
    check(dataPointer, 16'hABCD);
    pstep(DDPS_OP_INC, 16'h0000);
    check(dataPointer, 16'hABCE);
    // Toggling back must show pointer zero untouched by the other's ops.
    step(8'hA2, 1'b0, 1'b0, 1'b1, 8'h00);
    pstep(DDPS_OP_NONE, 16'h5555);
    check(dataPointer, 16'h0001);
    step(8'hA2, 1'b0, 1'b0, 1'b1, 8'h00);
    pstep(DDPS_OP_NONE, 16'h5555);
    check(dataPointer, 16'hABCE);
    // Reset in mid-run with the select and flag set.
    step(8'hA2, 1'b1, 1'b0, 1'b0, 8'h29);
    rst_n = 1'b0;
    @(negedge sys_clk);
    check({pointerSelectBit, userFlagBit, dataPointer}, 18'h0);
    rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    step(8'hA2, 1'b0, 1'b1, 1'b0, 8'h00);
    check(sfrReadData & 8'h05, 16'h00);
    check(pointerSelectBit, 1'b0);
    stop_test();
  end

endmodule
